// ===== hw/wake_pkg.sv
// constants, register map and field layout of the pin wakeup event counter
package wake_pkg;
  // bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 32'h5000_0100;
  localparam logic [ADDR_W-1:0] COMPARE_OFS = 32'h5000_0102;
  localparam logic [ADDR_W-1:0] IRQ_ACK_OFS = 32'h5000_0104;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 32'h5000_0106;
  localparam logic [ADDR_W-1:0] COUNT_CLEAR_OFS = 32'h5000_0108;
  localparam logic [ADDR_W-1:0] SEL0_OFS = 32'h5000_010A;
  localparam logic [ADDR_W-1:0] SEL1_OFS = 32'h5000_010C;
  localparam logic [ADDR_W-1:0] SEL2_OFS = 32'h5000_010E;
  localparam logic [ADDR_W-1:0] SEL3_OFS = 32'h5000_0110;
  localparam logic [ADDR_W-1:0] POL0_OFS = 32'h5000_0112;
  localparam logic [ADDR_W-1:0] POL1_OFS = 32'h5000_0114;
  localparam logic [ADDR_W-1:0] POL2_OFS = 32'h5000_0116;
  localparam logic [ADDR_W-1:0] POL3_OFS = 32'h5000_0118;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 32'h5000_011A;
  localparam logic [ADDR_W-1:0] STATUS_CLEAR_OFS = 32'h5000_011C;
  localparam logic [ADDR_W-1:0] STATUS_ENABLE_OFS = 32'h5000_011E;
  // pin counts per port and their place in the packed pin vector
  localparam int P0_W = 8;
  localparam int P1_W = 6;
  localparam int P2_W = 10;
  localparam int P3_W = 8;
  localparam int P0_LSB = 0;
  localparam int P1_LSB = 8;
  localparam int P2_LSB = 14;
  localparam int P3_LSB = 24;
  localparam int PIN_W = 32;
  // the emulated key rides on one extra bit above the pins
  localparam int KEY_BIT = 32;
  localparam int SRC_W = 33;
  // control register fields
  localparam int CTRL_IRQ_EN_BIT = 7;
  localparam int CTRL_SOFT_KEY_BIT = 6;
  localparam int DEB_W = 6;
  localparam int DEB_LSB = 0;
  localparam int COUNT_W = 8;
  // status bits
  localparam int STAT_W = 2;
  localparam int STAT_REACHED_BIT = 0;
  localparam int STAT_EVENT_BIT = 1;
  // reset values
  localparam logic [DEB_W-1:0] DEB_RST = 6'h00;
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic [COUNT_W-1:0] COMPARE_RST = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [PIN_W-1:0] SEL_RST = 32'h0000_0000;
  localparam logic [PIN_W-1:0] POL_RST = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STATUS_RST = 2'h0;
  localparam logic [STAT_W-1:0] STATUS_EN_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  // timing: one debounce step is one millisecond
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB_STEP_NS = 1000000;
  localparam int MS_CYCLES = DEB_STEP_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 16;
endpackage

// ===== hw/wake_debounce.sv
// group debouncer: passes the source vector on once it has been still long enough
`timescale 1ns/100ps
`default_nettype none
module wake_debounce
  import wake_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [DEB_W-1:0] deb_ms,
  input wire logic [SRC_W-1:0] raw,
  output logic [SRC_W-1:0] clean
);
  logic [SRC_W-1:0] last_q, last_d; // raw vector one cycle ago
  logic [MS_CNT_W-1:0] cyc_q, cyc_d; // cycles inside the current millisecond
  logic [DEB_W-1:0] still_q, still_d; // whole milliseconds without change
  logic [SRC_W-1:0] clean_q, clean_d; // filtered vector

  // the whole vector shares one timer: a bouncing pin delays the others,
  // traded for one counter instead of thirty-three
  always_comb begin
    last_d = raw;
    cyc_d = cyc_q;
    still_d = still_q;
    clean_d = clean_q;
    if (raw != last_q) begin
      // any change restarts the wait
      cyc_d = '0;
      still_d = '0;
    end else if (still_q != {DEB_W{1'b1}}) begin
      if (cyc_q == MS_CNT_W'(MS_CYCLES_P - 1)) begin
        cyc_d = '0;
        still_d = still_q + 1'b1;
      end else begin
        cyc_d = cyc_q + 1'b1;
      end
    end
    if (deb_ms == DEB_RST) begin
      // debouncing off: follow the input with one cycle of delay
      clean_d = raw; // RL10
    end else if (raw == last_q && still_q >= deb_ms) begin
      clean_d = raw; // RL10
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (srst) begin
      last_q <= '0;
      cyc_q <= '0;
      still_q <= '0;
      clean_q <= '0;
    end else if (ce) begin
      last_q <= last_d;
      cyc_q <= cyc_d;
      still_q <= still_d;
      clean_q <= clean_d;
    end
  end

  assign clean = clean_q;
endmodule // wake_debounce
`default_nettype wire

// ===== hw/pin_wakeup_event_counter.sv
// pin wakeup event counter with register port and masked interrupt
//
// Notes on behaviour
// RL1 - count register shows eight-bit count, upper zero
// RL2 - interrupt acknowledge clears the event count
// RL3 - any write to count clear zeroes count
// RL4 - ports 0 and 3: eight select bits
// RL5 - port 1: six select bits
// RL6 - port 2: ten select bits
// RL7 - unselected pins never touch the counter
// RL8 - polarity zero counts rising, one counts falling
// RL9 - enabled compare match raises wakeup interrupt
// RL10 - debounce zero off, else N milliseconds stable
// RL11 - software key bit rising counts one event
// RL12 - acknowledge write clears interrupt, reads zero; here it clears only the reached bit, an enabled event bit keeps irq high
// RL13 - synchronise pins, at most one count per cycle
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module pin_wakeup_event_counter
  import wake_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES // cycles per debounce millisecond
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [P0_W-1:0] port0_pins,
  input wire logic [P1_W-1:0] port1_pins,
  input wire logic [P2_W-1:0] port2_pins,
  input wire logic [P3_W-1:0] port3_pins,
  output logic irq
);
  // configuration registers
  logic wake_interrupt_enable_q, wake_interrupt_enable_d; // compare match may raise the wakeup flag
  logic software_key_emulation_q, software_key_emulation_d; // emulated key level
  logic [DEB_W-1:0] debounce_milliseconds_q, debounce_milliseconds_d; // debounce length
  logic [COUNT_W-1:0] event_compare_value_q, event_compare_value_d; // target count
  logic [P0_W-1:0] port0_source_enables_q, port0_source_enables_d;
  logic [P1_W-1:0] port1_source_enables_q, port1_source_enables_d;
  logic [P2_W-1:0] port2_source_enables_q, port2_source_enables_d;
  logic [P3_W-1:0] port3_source_enables_q, port3_source_enables_d;
  logic [P0_W-1:0] port0_edge_polarity_q, port0_edge_polarity_d;
  logic [P1_W-1:0] port1_edge_polarity_q, port1_edge_polarity_d;
  logic [P2_W-1:0] port2_edge_polarity_q, port2_edge_polarity_d;
  logic [P3_W-1:0] port3_edge_polarity_q, port3_edge_polarity_d;
  logic [STAT_W-1:0] status_enable_q, status_enable_d; // interrupt mask

  // counting state
  logic [COUNT_W-1:0] count_q, count_d; // running event count
  logic [STAT_W-1:0] status_q, status_d; // sticky events
  logic [DATA_W-1:0] rdata_q, rdata_d; // read answer, valid one cycle after rd

  // write decode
  logic count_clear_strobe; // write to the count clear register
  logic interrupt_acknowledge; // write to the interrupt reset register
  logic status_clear_wr; // write to the status clear register

  // pin path
  logic [PIN_W-1:0] pins_raw; // ports packed, port 0 lowest
  logic [PIN_W-1:0] sync1_q; // first synchroniser stage, read only by sync2_q
  logic [PIN_W-1:0] sync2_q; // second synchroniser stage
  logic [SRC_W-1:0] src_raw; // synchronised pins plus emulated key
  logic [SRC_W-1:0] src_clean; // debounced sources
  logic [SRC_W-1:0] src_prev_q; // debounced sources one cycle ago
  logic [PIN_W-1:0] sel_all; // select bits packed like the pins
  logic [PIN_W-1:0] pol_all; // polarity bits packed like the pins
  logic [PIN_W-1:0] pin_hit; // per pin qualifying edge this cycle
  logic key_hit; // emulated key went to one
  logic event_now; // count one event this cycle
  logic [COUNT_W-1:0] count_inc; // count after this event

  assign pins_raw = {port3_pins, port2_pins, port1_pins, port0_pins};
  assign sel_all = {port3_source_enables_q, port2_source_enables_q, port1_source_enables_q,
                    port0_source_enables_q};
  assign pol_all = {port3_edge_polarity_q, port2_edge_polarity_q, port1_edge_polarity_q,
                    port0_edge_polarity_q};

  // write strobes that carry no stored data; only the status clear uses the written value
  assign count_clear_strobe = wr && (addr == COUNT_CLEAR_OFS); // RL3
  assign interrupt_acknowledge = wr && (addr == IRQ_ACK_OFS); // RL12
  assign status_clear_wr = wr && (addr == STATUS_CLEAR_OFS);

  // two-stage synchroniser on every pin; the pins may be asynchronous keys
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= pins_raw; // RL13
      sync2_q <= sync1_q; // RL13
    end
  end

  assign src_raw = {software_key_emulation_q, sync2_q};

  // debouncing of pins and emulated key together
  wake_debounce #(
    .MS_CYCLES_P(MS_CYCLES_P)
  ) u_debounce (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .deb_ms(debounce_milliseconds_q),
    .raw(src_raw),
    .clean(src_clean)
  );

  // previous debounced value for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      src_prev_q <= '0;
    end else if (ce) begin
      src_prev_q <= src_clean;
    end
  end

  // per pin edge qualification: select gates, polarity picks the edge
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    assign pin_hit[i] = sel_all[i] && // RL7
                        (pol_all[i] ? (!src_clean[i] && src_prev_q[i]) // RL8
                                    : (src_clean[i] && !src_prev_q[i])); // RL8
  end

  // the emulated key counts on its debounced rising edge only, so software
  // must drop the bit before the next hit is seen
  assign key_hit = src_clean[KEY_BIT] && !src_prev_q[KEY_BIT]; // RL11

  // many simultaneous edges still make one count
  assign event_now = (|pin_hit) || key_hit; // RL13
  assign count_inc = count_q + 1'b1;

  // next values of the configuration registers
  always_comb begin
    wake_interrupt_enable_d = wake_interrupt_enable_q;
    software_key_emulation_d = software_key_emulation_q;
    debounce_milliseconds_d = debounce_milliseconds_q;
    event_compare_value_d = event_compare_value_q;
    port0_source_enables_d = port0_source_enables_q;
    port1_source_enables_d = port1_source_enables_q;
    port2_source_enables_d = port2_source_enables_q;
    port3_source_enables_d = port3_source_enables_q;
    port0_edge_polarity_d = port0_edge_polarity_q;
    port1_edge_polarity_d = port1_edge_polarity_q;
    port2_edge_polarity_d = port2_edge_polarity_q;
    port3_edge_polarity_d = port3_edge_polarity_q;
    status_enable_d = status_enable_q;
    if (wr) begin
      unique case (addr)
        CTRL_OFS: begin
          wake_interrupt_enable_d = wdata[CTRL_IRQ_EN_BIT];
          software_key_emulation_d = wdata[CTRL_SOFT_KEY_BIT]; // RL11
          debounce_milliseconds_d = wdata[DEB_LSB +: DEB_W]; // RL10
        end
        COMPARE_OFS: event_compare_value_d = wdata[COUNT_W-1:0];
        SEL0_OFS: port0_source_enables_d = wdata[P0_W-1:0]; // RL4
        SEL1_OFS: port1_source_enables_d = wdata[P1_W-1:0]; // RL5
        SEL2_OFS: port2_source_enables_d = wdata[P2_W-1:0]; // RL6
        SEL3_OFS: port3_source_enables_d = wdata[P3_W-1:0]; // RL4
        POL0_OFS: port0_edge_polarity_d = wdata[P0_W-1:0]; // RL8
        POL1_OFS: port1_edge_polarity_d = wdata[P1_W-1:0]; // RL8
        POL2_OFS: port2_edge_polarity_d = wdata[P2_W-1:0]; // RL8
        POL3_OFS: port3_edge_polarity_d = wdata[P3_W-1:0]; // RL8
        STATUS_ENABLE_OFS: status_enable_d = wdata[STAT_W-1:0];
        default: begin
          // read-only, write-only strobes and unmapped addresses store nothing
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_interrupt_enable_q <= CTRL_BIT_RST;
      software_key_emulation_q <= CTRL_BIT_RST;
      debounce_milliseconds_q <= DEB_RST;
      event_compare_value_q <= COMPARE_RST;
      port0_source_enables_q <= SEL_RST[P0_LSB +: P0_W];
      port1_source_enables_q <= SEL_RST[P1_LSB +: P1_W];
      port2_source_enables_q <= SEL_RST[P2_LSB +: P2_W];
      port3_source_enables_q <= SEL_RST[P3_LSB +: P3_W];
      port0_edge_polarity_q <= POL_RST[P0_LSB +: P0_W];
      port1_edge_polarity_q <= POL_RST[P1_LSB +: P1_W];
      port2_edge_polarity_q <= POL_RST[P2_LSB +: P2_W];
      port3_edge_polarity_q <= POL_RST[P3_LSB +: P3_W];
      status_enable_q <= STATUS_EN_RST;
    end else if (ce) begin
      wake_interrupt_enable_q <= wake_interrupt_enable_d;
      software_key_emulation_q <= software_key_emulation_d;
      debounce_milliseconds_q <= debounce_milliseconds_d;
      event_compare_value_q <= event_compare_value_d;
      port0_source_enables_q <= port0_source_enables_d;
      port1_source_enables_q <= port1_source_enables_d;
      port2_source_enables_q <= port2_source_enables_d;
      port3_source_enables_q <= port3_source_enables_d;
      port0_edge_polarity_q <= port0_edge_polarity_d;
      port1_edge_polarity_q <= port1_edge_polarity_d;
      port2_edge_polarity_q <= port2_edge_polarity_d;
      port3_edge_polarity_q <= port3_edge_polarity_d;
      status_enable_q <= status_enable_d;
    end
  end

  // next count and sticky status
  always_comb begin
    count_d = count_q;
    status_d = status_q;
    if (count_clear_strobe || interrupt_acknowledge) begin
      // an event in the clearing cycle survives as a count of one
      count_d = event_now ? {{(COUNT_W-1){1'b0}}, 1'b1} : COUNT_RST; // RL2 RL3
    end else if (event_now) begin
      count_d = count_inc; // wraps past full scale
    end
    // clears first, so that a set in the same cycle wins
    if (interrupt_acknowledge) begin
      status_d[STAT_REACHED_BIT] = 1'b0; // RL12
    end
    if (status_clear_wr) begin
      status_d = status_d & ~wdata[STAT_W-1:0];
    end
    if (event_now) begin
      status_d[STAT_EVENT_BIT] = 1'b1;
    end
    // match is judged on the value the count moves to
    if (event_now && wake_interrupt_enable_q && count_d == event_compare_value_q) begin
      status_d[STAT_REACHED_BIT] = 1'b1; // RL9
    end
  end

  // counting registers
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= COUNT_RST;
      status_q <= STATUS_RST;
    end else if (ce) begin
      count_q <= count_d;
      status_q <= status_d;
    end
  end

  // read answer; write-only registers and unmapped addresses give zero
  always_comb begin
    rdata_d = RDATA_RST;
    if (rd) begin
      unique case (addr)
        CTRL_OFS: begin
          rdata_d[CTRL_IRQ_EN_BIT] = wake_interrupt_enable_q;
          rdata_d[CTRL_SOFT_KEY_BIT] = software_key_emulation_q;
          rdata_d[DEB_LSB +: DEB_W] = debounce_milliseconds_q;
        end
        COMPARE_OFS: rdata_d = DATA_W'(event_compare_value_q);
        COUNT_OFS: rdata_d = DATA_W'(count_q); // RL1
        SEL0_OFS: rdata_d = DATA_W'(port0_source_enables_q);
        SEL1_OFS: rdata_d = DATA_W'(port1_source_enables_q);
        SEL2_OFS: rdata_d = DATA_W'(port2_source_enables_q);
        SEL3_OFS: rdata_d = DATA_W'(port3_source_enables_q);
        POL0_OFS: rdata_d = DATA_W'(port0_edge_polarity_q);
        POL1_OFS: rdata_d = DATA_W'(port1_edge_polarity_q);
        POL2_OFS: rdata_d = DATA_W'(port2_edge_polarity_q);
        POL3_OFS: rdata_d = DATA_W'(port3_edge_polarity_q);
        STATUS_OFS: rdata_d = DATA_W'(status_q);
        STATUS_ENABLE_OFS: rdata_d = DATA_W'(status_enable_q);
        default: rdata_d = RDATA_RST; // acknowledge, clears and unmapped read zero
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= RDATA_RST;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  // level interrupt while any enabled sticky bit is set
  assign irq = |(status_q & status_enable_q); // RL9
endmodule // pin_wakeup_event_counter
`default_nettype wire

// ===== sim/wake_keys_model.sv
// behavioural keys and switches on the four wakeup ports
`timescale 1ns/100ps
`default_nettype none
module wake_keys_model
  import wake_pkg::*;
(
  input wire logic clk,
  output logic [P0_W-1:0] port0_pins,
  output logic [P1_W-1:0] port1_pins,
  output logic [P2_W-1:0] port2_pins,
  output logic [P3_W-1:0] port3_pins
);
  // contact levels, every key open (low) at start; keys always drive, no float
  logic [PIN_W-1:0] lvl = '0;
  assign port0_pins = lvl[P0_LSB +: P0_W];
  assign port1_pins = lvl[P1_LSB +: P1_W];
  assign port2_pins = lvl[P2_LSB +: P2_W];
  assign port3_pins = lvl[P3_LSB +: P3_W];
  // prompt key: toggles the contacts in mask just after an edge
  task automatic flip(input logic [PIN_W-1:0] mask);
    @(posedge clk);
    lvl <= lvl ^ mask;
  endtask
  // slow key: chatters two cycles apart and settles toggled after 2n+1 moves
  task automatic chatter(input logic [PIN_W-1:0] mask, input int n);
    repeat (2 * n + 1) begin
      flip(mask);
      @(posedge clk);
    end
  endtask
endmodule // wake_keys_model
`default_nettype wire

// ===== sim/pin_wakeup_event_counter_asserts.sv
// checker for the register port and interrupt of the pin wakeup event counter
`timescale 1ns/100ps
`default_nettype none
module wake_counter_checker
  import wake_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES // cycles per millisecond, as in the design
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [P0_W-1:0] port0_pins,
  input wire logic [P1_W-1:0] port1_pins,
  input wire logic [P2_W-1:0] port2_pins,
  input wire logic [P3_W-1:0] port3_pins,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [3:0] sel_q, sel_d; // shadow: select register of each port non-zero
  logic key_q, key_d; // shadow of the soft key bit
  logic [1:0] sten_q, sten_d; // shadow of the status enable register
  logic [3:0] quiet_q, quiet_d; // running cycles with no source selected, saturating
  // shadows follow only the writes the block takes; ce low freezes them like the block
  always_comb begin
    sel_d = sel_q;
    key_d = key_q;
    sten_d = sten_q;
    quiet_d = quiet_q;
    for (int i = 0; i < 4; i++) begin
      if (ce && wr && addr == SEL0_OFS + 32'(2 * i)) begin
        sel_d[i] = |wdata;
      end
    end
    if (ce && wr && addr == CTRL_OFS) begin
      key_d = wdata[CTRL_SOFT_KEY_BIT];
    end
    if (ce && wr && addr == STATUS_ENABLE_OFS) begin
      sten_d = wdata[STAT_W-1:0];
    end
    // fifteen quiet cycles outlast the pin pipeline, so no late edge is in flight
    if (sel_q != 4'h0 || key_q) begin
      quiet_d = 4'h0;
    end else if (ce && quiet_q != 4'hF) begin
      quiet_d = quiet_q + 4'h1;
    end
  end
  // shadow registers
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_q <= 4'h0;
      key_q <= 1'b0;
      sten_q <= 2'h0;
      quiet_q <= 4'h0;
    end else begin
      sel_q <= sel_d;
      key_q <= key_d;
      sten_q <= sten_d;
      quiet_q <= quiet_d;
    end
  end
  a_rdata_idle: assert property (ce && !rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_count_upper: assert property (ce && rd && addr == COUNT_OFS |=> rdata[15:8] == 8'h00)
    else $error("count register upper byte not zero");
  a_ack_reads_zero: assert property (ce && rd && addr == IRQ_ACK_OFS |=> rdata == 16'h0000)
    else $error("acknowledge register read not zero");
  a_clear_reads_zero: assert property (ce && rd && addr == COUNT_CLEAR_OFS |=> rdata == 16'h0000)
    else $error("count clear register read not zero");
  a_clear_zeroes_count: assert property (ce && wr && addr == COUNT_CLEAR_OFS
    ##[1:2] ce && rd && addr == COUNT_OFS |=> rdata <= 16'h0004)
    else $error("count not cleared by count clear write");
  a_ack_zeroes_count: assert property (ce && wr && addr == IRQ_ACK_OFS
    ##[1:2] ce && rd && addr == COUNT_OFS |=> rdata <= 16'h0004)
    else $error("count not cleared by interrupt acknowledge");
  a_irq_needs_enable: assert property (irq |-> sten_q != 2'h0)
    else $error("interrupt high with every status bit masked");
  a_mask_drops_irq: assert property (ce && wr && addr == STATUS_ENABLE_OFS && wdata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt stays high after masking");
  a_unselected_quiet: assert property (quiet_q == 4'hF && !$past(wr) |-> !$rose(irq))
    else $error("interrupt raised with no source selected");
  a_ce_freezes: assert property (!ce |=> $stable(rdata) && $stable(irq))
    else $error("outputs moved while clock enable low");
  c_irq_raised: cover property ($rose(irq));
  c_count_read: cover property (ce && rd && addr == COUNT_OFS);
  c_frozen: cover property (!ce ##1 ce);
endmodule // wake_counter_checker
bind pin_wakeup_event_counter wake_counter_checker #(.MS_CYCLES_P(MS_CYCLES_P)) u_checker (
  .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .port0_pins(port0_pins), .port1_pins(port1_pins), .port2_pins(port2_pins), .port3_pins(port3_pins),
  .irq(irq)
);
`default_nettype wire

// ===== sim/pin_wakeup_event_counter_bench.sv
// self-checking bench for the pin wakeup event counter
`timescale 1ns/100ps
`default_nettype none
module pin_wakeup_event_counter_bench
  import wake_pkg::*;
;
  localparam int unsigned MS_SIM = 4; // four-cycle millisecond keeps debounce runs short
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [P0_W-1:0] p0;
  logic [P1_W-1:0] p1;
  logic [P2_W-1:0] p2;
  logic [P3_W-1:0] p3;
  logic irq;
  int fails = 0;
  int n_checks = 0;
  logic [7:0] exp_cnt = 8'h00; // count the bench expects
  logic [DATA_W-1:0] d; // last value read
  logic [PIN_W-1:0] m; // contacts being moved
  int wid_a [4] = '{P0_W, P1_W, P2_W, P3_W}; // pins per port
  int lsb_a [4] = '{P0_LSB, P1_LSB, P2_LSB, P3_LSB}; // first pin of each port
  // 40 MHz clock
  always #12.5 clk = ~clk;
  pin_wakeup_event_counter #(.MS_CYCLES_P(MS_SIM)) u_dut (
    .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .port0_pins(p0), .port1_pins(p1), .port2_pins(p2), .port3_pins(p3), .irq(irq)
  );
  wake_keys_model u_keys (.clk(clk), .port0_pins(p0), .port1_pins(p1), .port2_pins(p2), .port3_pins(p3));
  // one-cycle write; each access starts on a fresh edge so no strobe is set twice at once
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read; data stand only in the following cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // interrupt level, looked at once the edge's updates have landed
  task automatic chk_irq(input logic exp);
    #1;
    n_checks++;
    if (irq !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, irq, exp);
    end
  endtask
  task automatic chk_cnt();
    rd_reg(COUNT_OFS, d);
    chk16(d, {8'h00, exp_cnt});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: the tests need under two thousand cycles
  initial begin
    cyc(20000);
    fails++;
    wrap_up();
  end
  // main sequence
  initial begin
    cyc(12);
    srst <= 1'b0;
    // every register and the unmapped word above them read zero
    for (int a = 'h100; a <= 'h120; a += 2) begin
      rd_reg(32'h5000_0000 + 32'(a), d);
      chk16(d, 16'h0000);
    end
    chk_irq(1'b0);
    wr_reg(COUNT_OFS, 16'h00AA);
    chk_cnt();
    wr_reg(COMPARE_OFS, 16'hFFFF);
    rd_reg(COMPARE_OFS, d);
    chk16(d, 16'h00FF);
    $display("test reset and read-only done");
    // field widths; polarity and select never set together here
    for (int p = 0; p < 4; p++) begin
      wr_reg(POL0_OFS + 32'(2 * p), 16'hFFFF);
      rd_reg(POL0_OFS + 32'(2 * p), d);
      chk16(d, 16'((1 << wid_a[p]) - 1));
      wr_reg(POL0_OFS + 32'(2 * p), 16'h0000);
      wr_reg(SEL0_OFS + 32'(2 * p), 16'hFFFF);
      rd_reg(SEL0_OFS + 32'(2 * p), d);
      chk16(d, 16'((1 << wid_a[p]) - 1));
      wr_reg(SEL0_OFS + 32'(2 * p), 16'h0000);
    end
    chk_cnt();
    $display("test field widths done");
    // top pin of each port selected, its unselected neighbour moving alongside
    for (int p = 0; p < 4; p++) begin
      m = 32'h1 << (lsb_a[p] + wid_a[p] - 1);
      wr_reg(SEL0_OFS + 32'(2 * p), 16'(1 << (wid_a[p] - 1)));
      u_keys.flip(m);
      u_keys.flip(m >> 1);
      cyc(8);
      exp_cnt++;
      chk_cnt();
      wr_reg(POL0_OFS + 32'(2 * p), 16'(1 << (wid_a[p] - 1)));
      u_keys.flip(m);
      u_keys.flip(m >> 1);
      cyc(8);
      exp_cnt++;
      chk_cnt();
      u_keys.flip(m);
      cyc(8);
      chk_cnt();
      wr_reg(SEL0_OFS + 32'(2 * p), 16'h0000);
      wr_reg(POL0_OFS + 32'(2 * p), 16'h0000);
    end
    // two selected pins rising in one cycle give one event
    m = (32'h1 << P0_LSB) | (32'h1 << P2_LSB);
    wr_reg(SEL0_OFS, 16'h0001);
    wr_reg(SEL2_OFS, 16'h0001);
    u_keys.flip(m);
    cyc(8);
    exp_cnt++;
    chk_cnt();
    u_keys.flip(m);
    cyc(8);
    wr_reg(SEL2_OFS, 16'h0000);
    wr_reg(COUNT_CLEAR_OFS, 16'h5A5A);
    exp_cnt = 8'h00;
    chk_cnt();
    $display("test pin sources done");
    // compare match raises the interrupt, masking and acknowledge drop it
    m = 32'h1 << P0_LSB;
    wr_reg(COMPARE_OFS, 16'h0002);
    wr_reg(CTRL_OFS, 16'h0080);
    wr_reg(STATUS_ENABLE_OFS, 16'h0001);
    u_keys.flip(m);
    cyc(8);
    chk_irq(1'b0);
    u_keys.flip(m);
    u_keys.flip(m);
    cyc(8);
    chk_irq(1'b1);
    wr_reg(STATUS_ENABLE_OFS, 16'h0000);
    chk_irq(1'b0);
    wr_reg(STATUS_ENABLE_OFS, 16'h0001);
    chk_irq(1'b1);
    wr_reg(IRQ_ACK_OFS, 16'hFFFF);
    chk_irq(1'b0);
    chk_cnt();
    wr_reg(STATUS_ENABLE_OFS, 16'h0002);
    chk_irq(1'b1);
    wr_reg(STATUS_CLEAR_OFS, 16'h0002);
    chk_irq(1'b0);
    // match with the wake interrupt disabled; chatter counts each rise undebounced
    wr_reg(CTRL_OFS, 16'h0000);
    wr_reg(STATUS_ENABLE_OFS, 16'h0001);
    u_keys.chatter(m, 2);
    cyc(8);
    exp_cnt = 8'h02;
    chk_cnt();
    chk_irq(1'b0);
    wr_reg(STATUS_ENABLE_OFS, 16'h0000);
    $display("test interrupt done");
    // emulated key: one event per set, held bit does not repeat
    wr_reg(COUNT_CLEAR_OFS, 16'h0000);
    exp_cnt = 8'h01;
    wr_reg(CTRL_OFS, 16'h0040);
    cyc(4);
    chk_cnt();
    wr_reg(CTRL_OFS, 16'h0040);
    cyc(4);
    chk_cnt();
    wr_reg(CTRL_OFS, 16'h0000);
    wr_reg(CTRL_OFS, 16'h0040);
    cyc(4);
    exp_cnt++;
    chk_cnt();
    // longest debounce: chattering key counts once, only after 63 quiet milliseconds
    wr_reg(CTRL_OFS, 16'h003F);
    u_keys.chatter(m, 3);
    cyc(63 * MS_SIM - 20);
    chk_cnt();
    cyc(40);
    exp_cnt++;
    chk_cnt();
    wr_reg(CTRL_OFS, 16'h0000);
    $display("test key and debounce done");
    // clock enable low: a write is not taken
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(COMPARE_OFS, 16'h00A5);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(COMPARE_OFS, d);
    chk16(d, 16'h0002);
    // reset in mid-run clears the count
    @(posedge clk);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    exp_cnt = 8'h00;
    chk_cnt();
    chk_irq(1'b0);
    $display("test enable and reset done");
    wrap_up();
  end
endmodule // pin_wakeup_event_counter_bench
`default_nettype wire
